// ==== pkg/flash_front_pkg.sv ====
// Behaviour
// - select high deselects; every data lane output driver is released.
// - after power-up no instruction is taken until select has fallen from high.
// - single-lane instruction, address and data bits are sampled on rising clock edges.
// - single-lane read data and status change on falling clock edges.
// - clock modes 0 and 3 both work; idle clock level is ignored.
// - dual read instructions use lanes 0 and 1, two bits per clock.
// - quad instructions use lanes 0 to 3; others use only lanes 0 and 1.
// - dual/quad input captured on rising edges, output driven on falling edges.
// - power-on state takes its address mode from the power-up mode bit.
// - the power-up address mode bit comes out of reset as 0.
// - enter-4-byte and exit-4-byte instructions switch the address mode.
// - the current address mode bit always shows the mode in effect.
// - in 3-byte mode the extended address register supplies the upper address byte.
// - in 4-byte mode the four address bytes alone form the address.
// - software reset needs reset-enable then reset as consecutive instructions.
// - after software reset, instructions are refused for about 30 us.
// - the hardware reset pin low resets the device in any state; the code keeps the counter unit (busy timer and result run on) and the APB-written registers.
// - four 32-bit monotonic counters, each chosen by an 8-bit counter address.
// - increment-counter commands are authenticated by comparing a keyed hash with the supplied one; other counter commands are not checked.
// - write-root-key stores the key and clears the counters to zero; the code keeps no key, it only sets root_set.
// - once the root key is stored it is never changed nor sent out.
// - counter status bit 0 is 1 while a counter command executes.
`default_nettype none
package flash_front_pkg;
  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          TRST_US       = 30;
  localparam logic [11:0] TRST_COUNT    = 12'((TRST_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0]  OP_READ     = 8'h03;
  localparam logic [7:0]  OP_FAST     = 8'h0b;
  localparam logic [7:0]  OP_DUAL_OUT = 8'h3b;
  localparam logic [7:0]  OP_DUAL_IO  = 8'hbb;
  localparam logic [7:0]  OP_QUAD_OUT = 8'h6b;
  localparam logic [7:0]  OP_QUAD_IO  = 8'heb;
  localparam logic [7:0]  OP_RST_EN   = 8'h66;
  localparam logic [7:0]  OP_RST      = 8'h99;
  localparam logic [7:0]  OP_EN4      = 8'hb7;
  localparam logic [7:0]  OP_EX4      = 8'he9;
  localparam logic [7:0]  OP_RD_SR3   = 8'h15;
  localparam logic [7:0]  OP_WR_EXT   = 8'hc5;
  localparam logic [7:0]  OP_RD_EXT   = 8'hc8;
  localparam logic [7:0]  OP_CTR_CMD  = 8'h9b;
  localparam logic [7:0]  OP_CTR_STAT = 8'h96;
  localparam logic [3:0]  DUMMY_FAST    = 4'h8;
  localparam logic [3:0]  DUMMY_DUAL_IO = 4'h4;
  localparam logic [3:0]  DUMMY_QUAD_IO = 4'h6;
  localparam logic [2:0]  ADDR_BYTES_3  = 3'h3;
  localparam logic [2:0]  ADDR_BYTES_4  = 3'h4;
  localparam logic [7:0]  RP_BUSY         = 8'h01;
  localparam logic [7:0]  RP_ERR_OVERRITE = 8'h02;
  localparam logic [7:0]  RP_ERR_SIG      = 8'h04;
  localparam logic [7:0]  RP_ERR_UNINIT   = 8'h08;
  localparam logic [7:0]  RP_OK           = 8'h80;
  localparam logic [7:0]  RP_WRITE_ROOT   = 8'h00;
  localparam logic [7:0]  RP_INCREMENT    = 8'h02;
  localparam logic [5:0]  RP_BYTE_TYPE    = 6'h00;
  localparam logic [5:0]  RP_BYTE_CTR     = 6'h01;
  localparam logic [5:0]  RP_BYTE_TAG_END = 6'h05;
  localparam int          NUM_CTR = 4;
  localparam int          MEM_AW  = 4;
  localparam int          ADDR_W  = 12;
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_EXT      = 12'h008;
  localparam logic [11:0] REG_SIG      = 12'h00c;
  localparam logic [11:0] REG_CTR_STAT = 12'h010;
  localparam logic [11:0] REG_CNT_BASE = 12'h020;
  localparam logic [11:0] REG_MEM_BASE = 12'h040;

  typedef enum logic [2:0] {ph_idle, ph_opcode, ph_addr, ph_dummy, ph_din, ph_dout, ph_skip} phase_t;
  typedef enum logic [3:0] {k_none, k_read, k_sr3, k_rd_ext, k_wr_ext, k_en4, k_ex4,
                            k_rst_en, k_rst, k_op1, k_op2} kind_t;
  typedef struct packed {
    kind_t      kind;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
    logic       has_addr;
    logic [3:0] dummy;
  } op_info_t;
  typedef struct packed {
    logic       sclk;
    logic       cs_n;
    logic [3:0] lanes;
    logic       hw_rst_n;
  } pins_t;
  typedef struct packed {
    logic [25:0] unused;
    logic        rst_armed;
    logic        ctr_busy;
    logic        root_set;
    logic        in_reset;
    logic        pu_mode;
    logic        cur_mode;
  } status_t;

  function automatic op_info_t decode_op(input logic [7:0] op);
    op_info_t i;
    i = '{kind: k_none, addr_lanes: 3'h1, data_lanes: 3'h1, has_addr: 1'h0, dummy: 4'h0};
    case (op)
      OP_READ:     begin i.kind = k_read; i.has_addr = 1'h1; end
      OP_FAST:     begin i.kind = k_read; i.has_addr = 1'h1; i.dummy = DUMMY_FAST; end
      OP_DUAL_OUT: begin i.kind = k_read; i.has_addr = 1'h1; i.dummy = DUMMY_FAST; i.data_lanes = 3'h2; end
      OP_DUAL_IO:  begin i.kind = k_read; i.has_addr = 1'h1; i.dummy = DUMMY_DUAL_IO;
                         i.addr_lanes = 3'h2; i.data_lanes = 3'h2; end
      OP_QUAD_OUT: begin i.kind = k_read; i.has_addr = 1'h1; i.dummy = DUMMY_FAST; i.data_lanes = 3'h4; end
      OP_QUAD_IO:  begin i.kind = k_read; i.has_addr = 1'h1; i.dummy = DUMMY_QUAD_IO;
                         i.addr_lanes = 3'h4; i.data_lanes = 3'h4; end
      OP_RST_EN:   i.kind = k_rst_en;
      OP_RST:      i.kind = k_rst;
      OP_EN4:      i.kind = k_en4;
      OP_EX4:      i.kind = k_ex4;
      OP_RD_SR3:   i.kind = k_sr3;
      OP_WR_EXT:   i.kind = k_wr_ext;
      OP_RD_EXT:   i.kind = k_rd_ext;
      OP_CTR_CMD:  i.kind = k_op1;
      OP_CTR_STAT: i.kind = k_op2;
      default:     i.kind = k_none;
    endcase
    return i;
  endfunction : decode_op
endpackage : flash_front_pkg
`default_nettype wire

// ==== design/flash_front.sv ====
// The address map and the APB register port were decided locally.
`default_nettype none
module flash_front #(
  parameter int CTR_BUSY_CYCLES = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        hw_reset_n,
  input  wire logic [3:0]  data_lane_in,
  output logic      [3:0]  data_lane_out,
  output logic      [3:0]  data_lane_oe
);
  // pin synchroniser; s1 feeds only s2, s3 is a delayed copy for edge finding
  flash_front_pkg::pins_t s1;
  flash_front_pkg::pins_t s2;
  flash_front_pkg::pins_t s3;
  flash_front_pkg::pins_t pins_raw;
  localparam flash_front_pkg::pins_t PINS_IDLE = '{sclk: 1'h0, cs_n: 1'h1, lanes: 4'h0, hw_rst_n: 1'h1};

  assign pins_raw = '{sclk: sclk, cs_n: cs_n, lanes: data_lane_in, hw_rst_n: hw_reset_n};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= PINS_IDLE;
      s2 <= PINS_IDLE;
      s3 <= PINS_IDLE;
    end
    else
    begin
      s1 <= pins_raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // edges of the serial clock are found in the pclk domain; mode 0 and 3 differ only in idle level
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic hw_reset;
  logic serial_in_line;
  assign sclk_rise      = s2.sclk & ~s3.sclk & ~s2.cs_n;
  assign sclk_fall      = ~s2.sclk & s3.sclk & ~s2.cs_n;
  assign cs_fall        = ~s2.cs_n & s3.cs_n;
  assign cs_rise        = s2.cs_n & ~s3.cs_n;
  assign hw_reset       = ~s2.hw_rst_n;
  assign serial_in_line = s2.lanes[0];

  flash_front_pkg::phase_t   phase;
  flash_front_pkg::op_info_t info;
  flash_front_pkg::op_info_t dec;
  logic [3:0]  bitcnt;
  logic [7:0]  ish;
  logic [31:0] addr;
  logic [2:0]  abytes;
  logic [3:0]  dcnt;
  logic [5:0]  bytecnt;
  logic        op_seen;
  logic        current_addr_mode_bit;
  logic        power_up_addr_mode_bit;
  logic [7:0]  ext;
  logic        rst_armed;
  logic [11:0] rst_timer;
  logic        cs_seen_high;
  logic        frame_ok;

  function automatic flash_front_pkg::phase_t after_addr(input flash_front_pkg::op_info_t i);
    if (i.dummy != 4'h0)
      return flash_front_pkg::ph_dummy;
    else if (i.kind inside {flash_front_pkg::k_read, flash_front_pkg::k_sr3,
                            flash_front_pkg::k_rd_ext, flash_front_pkg::k_op2})
      return flash_front_pkg::ph_dout;
    else if (i.kind inside {flash_front_pkg::k_wr_ext, flash_front_pkg::k_op1})
      return flash_front_pkg::ph_din;
    else
      return flash_front_pkg::ph_skip;
  endfunction : after_addr

  // input collection: opcode always single lane, later phases use the instruction's lane count
  logic [2:0] w_in;
  logic [7:0] byte_in;
  logic [3:0] bits_after;
  logic       collecting;
  logic       byte_done;
  logic       addr_done;
  logic       din_done;
  logic [31:0] full_addr;
  assign w_in       = (phase == flash_front_pkg::ph_opcode) ? 3'h1 : info.addr_lanes;
  assign byte_in    = (w_in == 3'h4) ? {ish[3:0], s2.lanes} :
                      (w_in == 3'h2) ? {ish[5:0], s2.lanes[1:0]} :
                                       {ish[6:0], serial_in_line};
  assign bits_after = bitcnt + {1'h0, w_in};
  assign collecting = phase inside {flash_front_pkg::ph_opcode, flash_front_pkg::ph_addr,
                                    flash_front_pkg::ph_din};
  assign byte_done  = sclk_rise & collecting & (bits_after == 4'h8);
  assign addr_done  = byte_done & (phase == flash_front_pkg::ph_addr) & (abytes == 3'h1);
  assign din_done   = byte_done & (phase == flash_front_pkg::ph_din);
  assign dec        = flash_front_pkg::decode_op(byte_in);
  assign frame_ok   = cs_seen_high & (rst_timer == 12'h000);
  // 3-byte mode takes the top byte from the extended register; 4-byte mode ignores it
  assign full_addr  = current_addr_mode_bit ? {addr[23:0], byte_in}
                                            : {ext, addr[15:0], byte_in};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase   <= flash_front_pkg::ph_idle;
      info    <= '0;
      bitcnt  <= 4'h0;
      ish     <= 8'h00;
      addr    <= 32'h0000_0000;
      abytes  <= 3'h0;
      dcnt    <= 4'h0;
      bytecnt <= 6'h00;
      op_seen <= 1'h0;
    end
    else if (hw_reset)
    begin
      phase   <= s2.cs_n ? flash_front_pkg::ph_idle : flash_front_pkg::ph_skip;
      op_seen <= 1'h0;
    end
    else if (cs_rise)
    begin
      phase   <= flash_front_pkg::ph_idle;
      op_seen <= 1'h0;
    end
    else if (cs_fall)
    begin
      // refused frames are skipped whole until select rises again
      phase   <= frame_ok ? flash_front_pkg::ph_opcode : flash_front_pkg::ph_skip;
      bitcnt  <= 4'h0;
      bytecnt <= 6'h00;
    end
    else if (sclk_rise && collecting)
    begin
      ish    <= byte_in;
      bitcnt <= byte_done ? 4'h0 : bits_after;
      if (byte_done)
      begin
        case (phase)
          flash_front_pkg::ph_opcode:
          begin
            info    <= dec;
            op_seen <= 1'h1;
            abytes  <= current_addr_mode_bit ? flash_front_pkg::ADDR_BYTES_4 : flash_front_pkg::ADDR_BYTES_3;
            dcnt    <= dec.dummy;
            phase   <= dec.has_addr ? flash_front_pkg::ph_addr : after_addr(dec);
          end
          flash_front_pkg::ph_addr:
          begin
            addr   <= {addr[23:0], byte_in};
            abytes <= abytes - 3'h1;
            if (abytes == 3'h1)
              phase <= after_addr(info);
          end
          default:
          begin
            if (bytecnt != 6'h3f)
              bytecnt <= bytecnt + 6'h01;
          end
        endcase
      end
    end
    else if (sclk_rise && phase == flash_front_pkg::ph_dummy)
    begin
      dcnt <= dcnt - 4'h1;
      if (dcnt == 4'h1)
        phase <= flash_front_pkg::ph_dout;
    end
  end

  // address mode, extended address, software reset sequencing
  logic sw_reset;
  logic instr_end;
  logic [1:0] sync_live;
  assign instr_end = cs_rise & op_seen;
  assign sw_reset  = instr_end & (info.kind == flash_front_pkg::k_rst) & rst_armed;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      current_addr_mode_bit <= 1'h0;
      ext                   <= 8'h00;
      rst_armed             <= 1'h0;
      rst_timer             <= 12'h000;
      cs_seen_high          <= 1'h0;
      sync_live             <= 2'h0;
    end
    else
    begin
      // the synchroniser's reset level is no real pin level; wait until it has flushed
      sync_live <= {sync_live[0], 1'h1};
      if (s2.cs_n && sync_live[1])
        cs_seen_high <= 1'h1;
      if (hw_reset)
      begin
        current_addr_mode_bit <= power_up_addr_mode_bit;
        ext                   <= 8'h00;
        rst_armed             <= 1'h0;
        rst_timer             <= 12'h000;
      end
      else if (sw_reset)
      begin
        current_addr_mode_bit <= power_up_addr_mode_bit;
        ext                   <= 8'h00;
        rst_armed             <= 1'h0;
        rst_timer             <= flash_front_pkg::TRST_COUNT;
      end
      else
      begin
        if (rst_timer != 12'h000)
          rst_timer <= rst_timer - 12'h001;
        if (din_done && info.kind == flash_front_pkg::k_wr_ext && bytecnt == 6'h00)
          ext <= byte_in;
        if (instr_end)
        begin
          rst_armed <= (info.kind == flash_front_pkg::k_rst_en);
          if (info.kind == flash_front_pkg::k_en4)
            current_addr_mode_bit <= 1'h1;
          else if (info.kind == flash_front_pkg::k_ex4)
            current_addr_mode_bit <= 1'h0;
        end
      end
    end
  end

  // replay-protected counter unit
  logic [31:0] ctr [flash_front_pkg::NUM_CTR];
  logic [7:0]  rp_type;
  logic [7:0]  rp_ctr;
  logic [31:0] rp_tag;
  logic [31:0] sig_expect;
  logic        root_set;
  logic [7:0]  rp_timer;
  logic [7:0]  rp_result;
  logic [7:0]  rp_status;
  logic        rp_busy;
  logic        rp_start;
  logic        rp_ctr_ok;
  logic        rp_sig_ok;
  localparam logic [7:0] RP_BUSY_COUNT = 8'(CTR_BUSY_CYCLES);

  assign rp_busy   = (rp_timer != 8'h00);
  assign rp_status = rp_busy ? flash_front_pkg::RP_BUSY : rp_result;
  assign rp_start  = instr_end & (info.kind == flash_front_pkg::k_op1) & ~rp_busy;
  assign rp_ctr_ok = (rp_ctr < 8'(flash_front_pkg::NUM_CTR));
  // sig_expect stands for the keyed-hash engine result for the pending command
  assign rp_sig_ok = (rp_tag == sig_expect);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int k = 0; k < flash_front_pkg::NUM_CTR; k++)
        ctr[k] <= 32'h0000_0000;
      rp_type   <= 8'h00;
      rp_ctr    <= 8'h00;
      rp_tag    <= 32'h0000_0000;
      root_set  <= 1'h0;
      rp_timer  <= 8'h00;
      rp_result <= 8'h00;
    end
    else
    begin
      if (din_done && info.kind == flash_front_pkg::k_op1)
      begin
        if (bytecnt == flash_front_pkg::RP_BYTE_TYPE)
          rp_type <= byte_in;
        else if (bytecnt == flash_front_pkg::RP_BYTE_CTR)
          rp_ctr <= byte_in;
        else if (bytecnt <= flash_front_pkg::RP_BYTE_TAG_END)
          rp_tag <= {rp_tag[23:0], byte_in};
      end
      // the pin reset leaves counter work alone; only the software reset aborts it
      if (sw_reset)
        rp_timer <= 8'h00;
      else if (rp_start)
      begin
        if (rp_type == flash_front_pkg::RP_WRITE_ROOT)
        begin
          if (root_set)
            rp_result <= flash_front_pkg::RP_ERR_OVERRITE;
          else
          begin
            root_set <= 1'h1;
            for (int k = 0; k < flash_front_pkg::NUM_CTR; k++)
              ctr[k] <= 32'h0000_0000;
            rp_timer  <= RP_BUSY_COUNT;
            rp_result <= flash_front_pkg::RP_OK;
          end
        end
        else if (rp_type == flash_front_pkg::RP_INCREMENT)
        begin
          if (!root_set)
            rp_result <= flash_front_pkg::RP_ERR_UNINIT;
          else if (!rp_ctr_ok || !rp_sig_ok)
            rp_result <= flash_front_pkg::RP_ERR_SIG;
          else
          begin
            ctr[rp_ctr[1:0]] <= ctr[rp_ctr[1:0]] + 32'h0000_0001;
            rp_timer         <= RP_BUSY_COUNT;
            rp_result        <= flash_front_pkg::RP_OK;
          end
        end
        else
        begin
          rp_timer  <= RP_BUSY_COUNT;
          rp_result <= flash_front_pkg::RP_OK;
        end
      end
      else if (rp_busy)
        rp_timer <= rp_timer - 8'h01;
    end
  end

  // serial output path; the root key has no path here at all
  logic [7:0]  mem [2**flash_front_pkg::MEM_AW];
  logic [31:0] ptr;
  logic [7:0]  obuf;
  logic [3:0]  ocnt;
  logic [7:0]  src_byte;
  logic [7:0]  cur;
  logic [2:0]  w_out;
  logic [3:0]  lanes_next;
  logic [3:0]  oe_mask;
  logic        out_phase;

  assign src_byte   = (info.kind == flash_front_pkg::k_read)   ? mem[ptr[flash_front_pkg::MEM_AW-1:0]] :
                      (info.kind == flash_front_pkg::k_sr3)    ? {6'h00, power_up_addr_mode_bit,
                                                                   current_addr_mode_bit} :
                      (info.kind == flash_front_pkg::k_rd_ext) ? ext : rp_status;
  assign cur        = (ocnt == 4'h0) ? src_byte : obuf;
  assign w_out      = info.data_lanes;
  assign lanes_next = (w_out == 3'h4) ? cur[7:4] :
                      (w_out == 3'h2) ? {2'h0, cur[7:6]} :
                                        {2'h0, cur[7], 1'h0};
  assign oe_mask    = (w_out == 3'h4) ? 4'hf : (w_out == 3'h2) ? 4'h3 : 4'h2;
  assign out_phase  = (phase == flash_front_pkg::ph_dout) & ~s2.cs_n;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr           <= 32'h0000_0000;
      obuf          <= 8'h00;
      ocnt          <= 4'h0;
      data_lane_out <= 4'h0;
      data_lane_oe  <= 4'h0;
    end
    else
    begin
      if (addr_done)
        ptr <= full_addr;
      if (cs_fall)
        ocnt <= 4'h0;
      if (!out_phase)
        data_lane_oe <= 4'h0;
      else if (sclk_fall)
      begin
        data_lane_oe  <= oe_mask;
        data_lane_out <= lanes_next;
        obuf          <= cur << w_out;
        ocnt          <= ((ocnt == 4'h0) ? 4'h8 : ocnt) - {1'h0, w_out};
        if (ocnt == 4'h0 && info.kind == flash_front_pkg::k_read)
          ptr <= ptr + 32'h0000_0001;
      end
    end
  end

  // apb slave: zero wait, pready raised for the access phase of every transfer
  flash_front_pkg::status_t st;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        wr_go;
  logic        cnt_sel;
  logic        mem_sel;
  assign st      = '{unused: 26'h0, rst_armed: rst_armed, ctr_busy: rp_busy, root_set: root_set,
                     in_reset: (rst_timer != 12'h000), pu_mode: power_up_addr_mode_bit,
                     cur_mode: current_addr_mode_bit};
  assign cnt_sel = (paddr[11:4] == flash_front_pkg::REG_CNT_BASE[11:4]);
  assign mem_sel = (paddr[11:6] == flash_front_pkg::REG_MEM_BASE[11:6]);
  assign wr_go   = psel & penable & pready & pwrite & (paddr[1:0] == 2'h0);

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'h1;
    if (paddr[1:0] != 2'h0)
      rd_hit = 1'h0;
    else if (paddr == flash_front_pkg::REG_CTRL)
      rd_word = {31'h0, power_up_addr_mode_bit};
    else if (paddr == flash_front_pkg::REG_STATUS)
      rd_word = st;
    else if (paddr == flash_front_pkg::REG_EXT)
      rd_word = {24'h0, ext};
    else if (paddr == flash_front_pkg::REG_SIG)
      rd_word = sig_expect;
    else if (paddr == flash_front_pkg::REG_CTR_STAT)
      rd_word = {24'h0, rp_status};
    else if (cnt_sel)
      rd_word = ctr[paddr[3:2]];
    else if (mem_sel)
      rd_word = {24'h0, mem[paddr[5:2]]};
    else
      rd_hit = 1'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready                 <= 1'h0;
      prdata                 <= 32'h0000_0000;
      pslverr                <= 1'h0;
      power_up_addr_mode_bit <= 1'h0;
      sig_expect             <= 32'h0000_0000;
      for (int k = 0; k < 2**flash_front_pkg::MEM_AW; k++)
        mem[k] <= 8'h00;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel && !penable)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~rd_hit;
      end
      if (wr_go && paddr == flash_front_pkg::REG_CTRL)
        power_up_addr_mode_bit <= pwdata[0];
      if (wr_go && paddr == flash_front_pkg::REG_SIG)
        sig_expect <= pwdata;
      if (wr_go && mem_sel)
        mem[paddr[5:2]] <= pwdata[7:0];
    end
  end
endmodule : flash_front
`default_nettype wire

// ==== sim/flash_front_assertions.sv ====
`default_nettype none
module flash_front_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        hw_reset_n,
  input wire logic [3:0]  data_lane_out,
  input wire logic [3:0]  data_lane_oe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // pins pass a 2-flop sync, so allow 5 cycles of margin
  sequence deselected;
    cs_n [*5];
  endsequence
  sequence sclk_quiet;
    (!cs_n && $stable(sclk)) [*8];
  endsequence
  ready_pulse_a: assert property (pready |=> !pready) else $error("pready long");
  ready_setup_a: assert property ($rose(pready) |-> $past(psel) && !$past(penable)) else $error("pready early");
  misalign_err_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr) else $error("no pslverr");
  lanes_off_a: assert property (deselected |-> data_lane_oe == 4'h0) else $error("lane driven");
  lane_sets_a: assert property (data_lane_oe inside {4'h0, 4'h2, 4'h3, 4'hf}) else $error("bad lanes");
  out_hold_a: assert property (sclk_quiet |-> $stable(data_lane_out)) else $error("lane moved");
  drive_start_a: assert property ($rose(|data_lane_oe) |-> !cs_n && !sclk) else $error("drive early");
  hw_abort_a: assert property (!hw_reset_n [*5] |-> data_lane_oe == 4'h0) else $error("drive held");
endmodule : flash_front_assertions
bind flash_front flash_front_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .sclk, .cs_n, .hw_reset_n, .data_lane_out, .data_lane_oe);
`default_nettype wire

// ==== sim/spi_ctl_model.sv ====
`default_nettype none
module spi_ctl_model (
  input  wire logic       pclk,
  input  wire logic [3:0] lanes,
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] drive
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mode = 1'h0;
  initial
  begin
    sclk = 1'h0;
    cs_n = 1'h1;
    drive = 4'h0;
  end
  task automatic gap();
    repeat (8) @(posedge pclk);
  endtask : gap
  task automatic start();
    sclk <= mode;
    gap();
    cs_n <= 1'h0;
    gap();
  endtask : start
  task automatic stop();
    sclk <= mode;
    gap();
    cs_n <= 1'h1;
    gap();
  endtask : stop
  // idle lanes toggle so a released line never reads as a stale value
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk <= 1'h0;
      drive <= {~drive[3:1], tx[i]};
      gap();
      sclk <= 1'h1;
      rx[i] = lanes[1];
      gap();
    end
  endtask : xfer
endmodule : spi_ctl_model
`default_nettype wire

// ==== sim/flash_front_tb.sv ====
`default_nettype none
module flash_front_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, hw_reset_n = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sclk, cs_n;
  logic [3:0] drive, data_lane_out, data_lane_oe;
  wire logic [3:0] lanes = (data_lane_oe & data_lane_out) | (~data_lane_oe & drive);
  int n_fail = 0, comparisons = 0, cycles = 0;
  always #4 pclk = ~pclk;
  flash_front #(.CTR_BUSY_CYCLES(40)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sclk, .cs_n, .hw_reset_n, .data_lane_in(lanes), .data_lane_out, .data_lane_oe);
  spi_ctl_model u_ctl (.pclk, .lanes, .sclk, .cs_n, .drive);
  task automatic conclude();
    $display("counts: %0d compared, %0d failed", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic st(input logic [31:0] exp);
    logic [31:0] r;
    apb(1'h0, flash_front_pkg::REG_STATUS, 32'h0, r);
    chk(r, exp);
  endtask : st
  task automatic frame(input logic [7:0] op);
    logic [7:0] rx;
    u_ctl.start();
    u_ctl.xfer(op, rx);
    u_ctl.stop();
  endtask : frame
  task automatic hw_pulse();
    hw_reset_n <= 1'h0;
    repeat (6) @(posedge pclk);
    hw_reset_n <= 1'h1;
    repeat (4) @(posedge pclk);
  endtask : hw_pulse
  task automatic t_read(input logic m, input logic n4);
    logic [31:0] r;
    logic [7:0] rx;
    apb(1'h1, flash_front_pkg::REG_MEM_BASE + 12'h00c, {24'h0, 7'h2d, m}, r);
    u_ctl.mode = m;
    u_ctl.start();
    u_ctl.xfer(flash_front_pkg::OP_READ, rx);
    u_ctl.xfer(8'h00, rx);
    if (n4)
      u_ctl.xfer(8'h00, rx);
    u_ctl.xfer(8'h00, rx);
    u_ctl.xfer(8'h03, rx);
    u_ctl.xfer(8'h00, rx);
    u_ctl.stop();
    chk({24'h0, rx}, {24'h0, 7'h2d, m});
    $display("t_read end");
  endtask : t_read
  task automatic t_power();
    logic [31:0] r;
    st(32'h0);
    apb(1'h0, 12'h002, 32'h0, r);
    chk(r, 32'h0);
    apb(1'h1, flash_front_pkg::REG_CTRL, 32'h1, r);
    hw_pulse();
    st(32'h3);
    apb(1'h1, flash_front_pkg::REG_CTRL, 32'h0, r);
    hw_pulse();
    st(32'h0);
    $display("t_power end");
  endtask : t_power
  task automatic t_mode();
    logic [7:0] rx;
    frame(flash_front_pkg::OP_EN4);
    st(32'h1);
    u_ctl.start();
    u_ctl.xfer(flash_front_pkg::OP_RD_SR3, rx);
    u_ctl.xfer(8'h00, rx);
    u_ctl.stop();
    chk({24'h0, rx}, 32'h1);
    t_read(1'h0, 1'h1);
    frame(flash_front_pkg::OP_EX4);
    st(32'h0);
    $display("t_mode end");
  endtask : t_mode
  task automatic t_swrst();
    frame(flash_front_pkg::OP_RST_EN);
    st(32'h20);
    frame(flash_front_pkg::OP_EN4);
    frame(flash_front_pkg::OP_RST);
    st(32'h1);
    frame(flash_front_pkg::OP_RST_EN);
    frame(flash_front_pkg::OP_RST);
    st(32'h4);
    frame(flash_front_pkg::OP_EN4);
    st(32'h4);
    repeat (flash_front_pkg::TRST_COUNT) @(posedge pclk);
    st(32'h0);
    $display("t_swrst end");
  endtask : t_swrst
  task automatic t_ctr();
    logic [31:0] r;
    logic [7:0] rx;
    apb(1'h1, flash_front_pkg::REG_SIG, 32'h1234_5678, r);
    for (int k = 0; k < 3; k++)
    begin
      u_ctl.start();
      u_ctl.xfer(flash_front_pkg::OP_CTR_CMD, rx);
      u_ctl.xfer(8'(k % 2 * 2), rx);
      u_ctl.xfer(8'h01, rx);
      for (int j = 0; j < 4; j++)
        u_ctl.xfer(8'(8'h12 + j * 8'h22), rx);
      u_ctl.stop();
      apb(1'h0, flash_front_pkg::REG_CTR_STAT, 32'h0, r);
      chk(r, (k == 2) ? 32'h2 : 32'h1);
      repeat (40) @(posedge pclk);
      apb(1'h0, flash_front_pkg::REG_CTR_STAT, 32'h0, r);
      chk(r, (k == 2) ? 32'h2 : 32'h80);
    end
    apb(1'h0, flash_front_pkg::REG_CNT_BASE + 12'h004, 32'h0, r);
    chk(r, 32'h1);
    st(32'h8);
    $display("t_ctr end");
  endtask : t_ctr
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    t_power();
    t_mode();
    t_read(1'h0, 1'h0);
    t_read(1'h1, 1'h0);
    t_swrst();
    t_ctr();
    conclude();
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      conclude();
    end
  end
endmodule : flash_front_tb
`default_nettype wire
